//--- core/selfprog_ctrl.sv
/*
 * Self-programming sequencer: an APB control/status register arms a store
 * command for a short window; the core's store and load strobes then fill
 * the page buffer, erase or write a page, set boot locks or read locks.
 * Assumes the core raises spm_store / lpm_load for one cycle per
 * instruction and honours core_stall. The flash array is outside; this
 * block only issues its page command and times it.
 */
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module selfprog_ctrl
    import selfprog_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int PAGE_LSB = 8,
    parameter logic [7:0] OP_CYCLES = OP_CYCLES_DEF,
    parameter logic [15:0] BOOT_START = 16'hE000,
    parameter logic [15:0] NO_RWW_START = 16'hE000
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic spm_store,
    input wire logic lpm_load,
    input wire logic [ADDR_W-1:0] z_ptr,
    input wire logic [15:0] r1_r0,
    input wire logic exec_boot,
    input wire logic vectors_in_boot,
    input wire logic global_irq_en,
    output logic [7:0] load_data,
    output logic load_valid,
    output logic load_denied,
    output logic fill_strobe,
    output logic [ADDR_W-1:0] fill_addr,
    output logic [15:0] fill_data,
    output logic page_erase_go,
    output logic page_write_go,
    output logic [ADDR_W-1:0] page_addr,
    output logic core_stall,
    output logic rww_read_block,
    output logic store_ready_irq,
    output logic irq_allowed,
    output logic ext_prog_allowed,
    output logic ext_verify_allowed,
    output logic fuse_change_allowed
);
    import selfprog_pkg::*;

    typedef enum logic [1:0] {IDLE, ARMED, BUSY} state_e;

    state_e state_q, state_d;
    logic [4:0] cmd_q, cmd_d;
    logic [2:0] win_q, win_d;
    logic [2:0] lwin_q, lwin_d;
    logic [7:0] busy_cnt_q, busy_cnt_d;
    logic busy_no_rww_q, busy_no_rww_d;
    logic rww_busy_q, rww_busy_d;
    logic irq_en_q;
    logic [7:0] lock_q;
    logic [7:0] fuse_q;
    logic [31:0] prdata_q;
    logic [7:0] load_data_q;
    logic load_valid_q, load_denied_q;
    logic fill_q, erase_go_q, write_go_q;
    logic [ADDR_W-1:0] fill_addr_q, page_addr_q;
    logic [15:0] fill_data_q;

    // ========================================================================
    // APB decode; every access completes in its first access cycle.
    wire wr_en = psel & penable & pwrite;
    // Read data is latched in the setup cycle so that it stands at the access edge.
    wire rd_setup = psel & ~penable & ~pwrite;
    wire hit_ctrl = (paddr == CTRL_OFFSET);
    wire hit_lock = (paddr == LOCK_OFFSET);
    wire hit_fuse = (paddr == FUSE_OFFSET);
    wire hit_status = (paddr == STATUS_OFFSET);
    wire hit_erase = (paddr == ERASE_OFFSET);
    wire mapped = hit_ctrl | hit_lock | hit_fuse | hit_status | hit_erase;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_q;

    // ========================================================================
    // Command decode of the low five control bits.
    wire [4:0] wr_cmd = pwdata[4:0];
    wire ctrl_wr = wr_en & hit_ctrl;
    wire pattern_ok = (wr_cmd == CMD_LOCKSET) | (wr_cmd == CMD_WRITE)
        | (wr_cmd == CMD_ERASE) | (wr_cmd == CMD_FILL)
        | (wr_cmd == CMD_RWW_EN); // [R10]
    // A new command is refused while busy; one operation at a time.
    wire arm = ctrl_wr & pattern_ok & (state_q != BUSY); // [R10] [R25] [R11]

    // ========================================================================
    // Store target decode and protection check.
    wire [ADDR_W-1:0] page_base = {z_ptr[ADDR_W-1:PAGE_LSB], {PAGE_LSB{1'b0}}};
    wire target_boot = (z_ptr >= BOOT_START);
    wire target_no_rww = (z_ptr >= NO_RWW_START);
    logic store_allowed, load_allowed, g_irq_ok, boot_lock_ok;

    selfprog_lock_guard u_guard (
        .lock_bits(lock_q),
        .target_boot(target_boot),
        .exec_boot(exec_boot),
        .vectors_in_boot(vectors_in_boot),
        .store_allowed(store_allowed),
        .load_allowed(load_allowed),
        .irq_allowed(g_irq_ok),
        .ext_prog_allowed(ext_prog_allowed),
        .ext_verify_allowed(ext_verify_allowed),
        .fuse_change_allowed(fuse_change_allowed),
        .boot_lock_change_allowed(boot_lock_ok)
    );
    assign irq_allowed = g_irq_ok;

    wire take_store = (state_q == ARMED) & spm_store; // [R6]
    wire do_lockset = take_store & (cmd_q == CMD_LOCKSET);
    wire do_erase = take_store & (cmd_q == CMD_ERASE) & store_allowed;
    wire do_write = take_store & (cmd_q == CMD_WRITE) & store_allowed;
    wire do_fill = take_store & (cmd_q == CMD_FILL);
    wire do_rww_en = take_store & (cmd_q == CMD_RWW_EN);
    wire start_op = do_erase | do_write;
    wire lock_read = (lwin_q != 3'd0) & (cmd_q == CMD_LOCKSET) & lpm_load; // [R2]

    // ========================================================================
    // Sequencer next state: arm, take one store, or time out.
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        win_d = win_q;
        lwin_d = (lwin_q != 3'd0) ? lwin_q - 3'd1 : 3'd0;
        busy_cnt_d = busy_cnt_q;
        busy_no_rww_d = busy_no_rww_q;
        case (state_q)
            IDLE, ARMED: begin
                if (arm) begin
                    state_d = ARMED;
                    cmd_d = wr_cmd;
                    win_d = STORE_WINDOW; // [R6]
                    lwin_d = (wr_cmd == CMD_LOCKSET) ? LOAD_WINDOW : 3'd0; // [R2]
                end else if (start_op) begin
                    state_d = BUSY; // [R9]
                    busy_cnt_d = OP_CYCLES;
                    busy_no_rww_d = target_no_rww;
                end else if (take_store || win_q == 3'd1) begin
                    state_d = IDLE; // [R8] [R1] [R3] [R5]
                    cmd_d = 5'h00;
                    win_d = 3'd0;
                end else if (state_q == ARMED) begin
                    win_d = win_q - 3'd1;
                end
            end
            BUSY: begin
                if (busy_cnt_q == 8'd1) begin
                    state_d = IDLE; // [R9] [R3] [R5]
                    cmd_d = 5'h00;
                    win_d = 3'd0;
                    busy_no_rww_d = 1'b0;
                end
                busy_cnt_d = busy_cnt_q - 8'd1;
            end
            default: state_d = IDLE;
        endcase
    end

    // Read-while-write busy: set by an RWW-side operation, cleared by the
    // re-enable store or by a buffer fill.
    always_comb begin
        rww_busy_d = rww_busy_q;
        if (start_op && !target_no_rww) begin
            rww_busy_d = 1'b1; // [R24]
        end else if (do_rww_en || do_fill) begin
            rww_busy_d = 1'b0;
        end
    end

    // ========================================================================
    // Sequencer registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= IDLE;
            cmd_q <= 5'h00;
            win_q <= 3'd0;
            lwin_q <= 3'd0;
            busy_cnt_q <= 8'h00;
            busy_no_rww_q <= 1'b0;
            rww_busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            win_q <= win_d;
            lwin_q <= lwin_d;
            busy_cnt_q <= busy_cnt_d;
            busy_no_rww_q <= busy_no_rww_d;
            rww_busy_q <= rww_busy_d;
        end
    end

    // ========================================================================
    // Lock and fuse storage; programming can only clear bits, and only the
    // chip erase key restores the lock bits, so a stray store can never unlock.
    wire chip_erase = wr_en & hit_erase & (pwdata[7:0] == CHIP_ERASE_KEY);
    // Only r0 bits 5:2 reach the boot lock bits; the two low lock bits are kept.
    wire [7:0] lock_prog = {2'b11, r1_r0[5:2], 2'b11};
    // The two low lock bits may always be programmed further from outside, but
    // the boot lock bits freeze once both of them are programmed.
    wire [3:0] ext_boot_bits = boot_lock_ok ? pwdata[5:2] : 4'hF;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= LOCK_RESET;
            fuse_q <= FUSE_RESET;
        end else if (chip_erase) begin
            lock_q <= LOCK_RESET; // [R13] [R12]
        end else if (do_lockset && boot_lock_ok) begin
            lock_q <= lock_q & lock_prog; // [R1] [R13]
        end else if (wr_en && hit_fuse && fuse_change_allowed) begin
            fuse_q <= fuse_q & pwdata[7:0]; // [R14]
        end else if (wr_en && hit_lock) begin
            lock_q <= lock_q & {2'b11, ext_boot_bits, pwdata[1:0]}; // [R13] [R12] [R15]
        end
    end

    // ========================================================================
    // Interrupt enable and outputs derived from state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= 1'b0;
        end else if (ctrl_wr) begin
            irq_en_q <= pwdata[IRQ_EN_BIT];
        end
    end

    wire store_en_view = (state_q != IDLE); // [R9]
    assign store_ready_irq = irq_en_q & global_irq_en & ~store_en_view; // [R23]
    assign core_stall = (state_q == BUSY) & busy_no_rww_q; // [R4]
    assign rww_read_block = rww_busy_q; // [R24]

    // ========================================================================
    // Read data mux and pulse outputs.
    wire [7:0] ctrl_view = {irq_en_q, rww_busy_q, 1'b0, 5'h00}
        | {3'b000, (store_en_view ? cmd_q : 5'h00)};
    wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_view}
        : hit_lock ? {24'h000000, lock_q}
        : hit_fuse ? {24'h000000, fuse_q}
        : hit_status ? {24'h000000, busy_cnt_q}
        : 32'h00000000;
    wire load_block = ~load_allowed | (rww_busy_q & ~target_no_rww); // [R17] [R20] [R24]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            load_data_q <= 8'h00;
            load_valid_q <= 1'b0;
            load_denied_q <= 1'b0;
            fill_q <= 1'b0;
            erase_go_q <= 1'b0;
            write_go_q <= 1'b0;
            fill_addr_q <= '0;
            fill_data_q <= 16'h0000;
            page_addr_q <= '0;
        end else begin
            prdata_q <= rd_setup ? rd_mux : prdata_q;
            load_valid_q <= lock_read;
            load_denied_q <= lpm_load & ~lock_read & load_block;
            if (lock_read) begin
                load_data_q <= z_ptr[0] ? fuse_q : lock_q; // [R2]
            end
            fill_q <= do_fill;
            if (do_fill) begin
                fill_addr_q <= {z_ptr[ADDR_W-1:1], 1'b0}; // [R7]
                fill_data_q <= r1_r0; // [R7]
            end
            erase_go_q <= do_erase; // [R5] [R16] [R19]
            write_go_q <= do_write; // [R3] [R16] [R19]
            if (start_op) begin
                page_addr_q <= page_base; // [R3] [R5]
            end
        end
    end

    assign load_data = load_data_q;
    assign load_valid = load_valid_q;
    assign load_denied = load_denied_q;
    assign fill_strobe = fill_q;
    assign fill_addr = fill_addr_q;
    assign fill_data = fill_data_q;
    assign page_erase_go = erase_go_q;
    assign page_write_go = write_go_q;
    assign page_addr = page_addr_q;
endmodule
`default_nettype wire

//--- core/selfprog_pkg.sv
/*
 * Shared constants for the self-programming control and lock block:
 * register offsets, control bit positions, lock byte layout, reset values
 * and the arming window lengths.
 * Assumes an APB master with 32-bit data and word-aligned register offsets.
 */
// Functional notes
// R1 - Lock-set store programs boot locks from r0
// R2 - Load after lock-set reads lock or fuse
// R3 - Page-write store writes buffer to page
// R4 - Stall core during no-RWW page operation
// R5 - Page-erase store erases pointer page
// R6 - Store enable allows store four cycles
// R7 - Plain store fills buffer, pointer LSB ignored
// R8 - Store enable clears after store or timeout
// R9 - Store enable stays set while busy
// R10 - Only five command patterns take effect
// R11 - Software keeps one store in progress
// R12 - Six lock bits, top two read one
// R13 - Only chip erase restores lock bits
// R14 - Lock mode two blocks external programming
// R15 - Lock mode three blocks programming and verify
// R16 - App lock low forbids application writes
// R17 - App lock high forbids boot-side reads
// R18 - App modes mask interrupts in application
// R19 - Boot lock low forbids boot writes
// R20 - Boot lock high forbids app-side reads
// R21 - Boot modes mask interrupts in boot
// R22 - Program fuses and boot locks first
// R23 - Store-ready interrupt while store enable clear
// R24 - RWW operation sets busy, blocks reads
// R25 - Ignored pattern changes nothing; the code still loads the interrupt enable bit from it
package selfprog_pkg;

    // ========================================================================
    // Register offsets (byte addresses).
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] LOCK_OFFSET = 8'h04;
    localparam logic [7:0] FUSE_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0C;
    localparam logic [7:0] ERASE_OFFSET = 8'h10;

    // ========================================================================
    // Control register bit positions.
    localparam int STORE_EN_BIT = 0;
    localparam int ERASE_BIT = 1;
    localparam int WRITE_BIT = 2;
    localparam int LOCKSET_BIT = 3;
    localparam int RWW_BUSY_BIT = 6;
    localparam int IRQ_EN_BIT = 7;

    // Accepted lower-five-bit command patterns.
    localparam logic [4:0] CMD_LOCKSET = 5'h09;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_FILL = 5'h01;
    localparam logic [4:0] CMD_RWW_EN = 5'h11;

    // ========================================================================
    // Lock byte layout; one means unprogrammed.
    localparam int LOCK_ONE_POS = 0;
    localparam int LOCK_TWO_POS = 1;
    localparam int APP_LO_POS = 2;
    localparam int APP_HI_POS = 3;
    localparam int BOOT_LO_POS = 4;
    localparam int BOOT_HI_POS = 5;
    localparam logic [7:0] LOCK_RESET = 8'hFF;
    localparam logic [7:0] FUSE_RESET = 8'hFF;
    localparam logic [7:0] CHIP_ERASE_KEY = 8'hA5;

    // ========================================================================
    // Timing.
    localparam logic [2:0] STORE_WINDOW = 3'd4;
    localparam logic [2:0] LOAD_WINDOW = 3'd3;
    localparam logic [7:0] OP_CYCLES_DEF = 8'd16;

endpackage

//--- core/selfprog_lock_guard.sv
/*
 * Lock-bit decoder: turns the lock byte into access permissions for
 * stores, loads, interrupts and the external programming port.
 * Assumes the caller says which section the core executes from and which
 * section an access targets.
 */
`timescale 1ns/1ps
`default_nettype none
module selfprog_lock_guard
    import selfprog_pkg::*;
(
    input wire logic [7:0] lock_bits,
    input wire logic target_boot,
    input wire logic exec_boot,
    input wire logic vectors_in_boot,
    output logic store_allowed,
    output logic load_allowed,
    output logic irq_allowed,
    output logic ext_prog_allowed,
    output logic ext_verify_allowed,
    output logic fuse_change_allowed,
    output logic boot_lock_change_allowed
);
    import selfprog_pkg::*;

    // ========================================================================
    // Decode; a zero bit is a programmed lock.
    wire app_lo = ~lock_bits[APP_LO_POS];
    wire app_hi = ~lock_bits[APP_HI_POS];
    wire boot_lo = ~lock_bits[BOOT_LO_POS];
    wire boot_hi = ~lock_bits[BOOT_HI_POS];
    wire lock_one = ~lock_bits[LOCK_ONE_POS];
    wire lock_two = ~lock_bits[LOCK_TWO_POS];

    // Section-selected write and read protection.
    assign store_allowed = target_boot ? ~boot_lo : ~app_lo; // [R16] [R19]
    assign load_allowed = ~((app_hi & exec_boot & ~target_boot) // [R17]
        | (boot_hi & ~exec_boot & target_boot)); // [R20]
    // Interrupts are cut when code runs in a read-protected section and the vectors sit on the far side.
    assign irq_allowed = ~((app_hi & vectors_in_boot & ~exec_boot) // [R18]
        | (boot_hi & ~vectors_in_boot & exec_boot)); // [R21]
    assign ext_prog_allowed = ~lock_one; // [R14] [R15]
    assign ext_verify_allowed = ~(lock_one & lock_two); // [R15]
    assign fuse_change_allowed = ~lock_one; // [R14]
    assign boot_lock_change_allowed = ~(lock_one & lock_two); // [R15]
endmodule
`default_nettype wire

//--- tb/selfprog_checker.sv
/*
 * Concurrent checks on the self-programming sequencer's ports.
 * Assumes one clock, pclk, and the async active-low reset presetn.
 */
`timescale 1ns/1ps
`default_nettype none
module selfprog_checker #(
    parameter int ADDR_W = 16,
    parameter logic [7:0] OP_CYCLES = 8'd16,
    parameter logic [15:0] NO_RWW_START = 16'hE000
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic spm_store,
    input wire logic lpm_load,
    input wire logic global_irq_en,
    input wire logic load_valid,
    input wire logic fill_strobe,
    input wire logic [ADDR_W-1:0] fill_addr,
    input wire logic page_erase_go,
    input wire logic page_write_go,
    input wire logic [ADDR_W-1:0] page_addr,
    input wire logic core_stall,
    input wire logic rww_read_block,
    input wire logic store_ready_irq
);
    // Margin on the stall length, since the busy count may include entry cycles.
    localparam int STALL_MAX = int'(OP_CYCLES) + 8;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========================================================================
    // Page operation steps: the launch pulse, then the stall falling.
    sequence s_op_start;
        page_erase_go || page_write_go;
    endsequence
    sequence s_op_tail;
        ##[0:STALL_MAX] !core_stall;
    endsequence
    a_fill_from_store: assert property (fill_strobe |-> $past(spm_store))
        else $error("buffer fill without a store");
    a_fill_even_addr: assert property (fill_strobe |-> !fill_addr[0])
        else $error("buffer fill address is odd");
    a_fill_single: assert property (fill_strobe |=> !fill_strobe)
        else $error("buffer fill repeated");
    a_erase_from_store: assert property (page_erase_go |-> $past(spm_store))
        else $error("page erase without a store");
    a_write_from_store: assert property (page_write_go |-> $past(spm_store))
        else $error("page write without a store");
    a_op_exclusive: assert property (s_op_start |-> !(page_erase_go && page_write_go))
        else $error("erase and write launched together");
    a_stall_bounded: assert property ($rose(core_stall) |-> s_op_start ##1 s_op_tail)
        else $error("stall without launch or too long");
    a_op_busy_gap: assert property (s_op_start |=> (!page_erase_go && !page_write_go) [*3])
        else $error("new page operation while busy");
    a_load_from_load: assert property (load_valid |-> $past(lpm_load))
        else $error("load answer without a load");
    a_irq_needs_global: assert property (store_ready_irq |-> global_irq_en)
        else $error("store ready interrupt with interrupts off");
    a_rww_blocked: assert property (s_op_start ##0 (page_addr < NO_RWW_START)
        |-> ##[0:1] rww_read_block)
        else $error("rww section not blocked");
endmodule
bind selfprog_ctrl selfprog_checker #(.ADDR_W(ADDR_W), .OP_CYCLES(OP_CYCLES),
    .NO_RWW_START(NO_RWW_START)) chk_u (.pclk(pclk), .presetn(presetn), .spm_store(spm_store),
    .lpm_load(lpm_load), .global_irq_en(global_irq_en), .load_valid(load_valid),
    .fill_strobe(fill_strobe), .fill_addr(fill_addr), .page_erase_go(page_erase_go),
    .page_write_go(page_write_go), .page_addr(page_addr), .core_stall(core_stall),
    .rww_read_block(rww_read_block), .store_ready_irq(store_ready_irq));
`default_nettype wire

//--- tb/core_model.sv
/*
 * Behavioural processor core issuing store and load instructions.
 * Assumes tasks are called right after a rising edge of pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic pclk,
    input wire logic core_stall,
    output logic spm_store,
    output logic lpm_load,
    output logic [15:0] z_ptr,
    output logic [15:0] r1_r0
);
    initial begin
        spm_store = 1'b0;
        lpm_load = 1'b0;
        z_ptr = 16'h0000;
        r1_r0 = 16'h0000;
    end
    // A halted core issues no store; one instruction at a time.
    task automatic store(input logic [15:0] z, input logic [15:0] d);
        while (core_stall === 1'b1) @(posedge pclk);
        spm_store <= 1'b1;
        z_ptr <= z;
        r1_r0 <= d;
        @(posedge pclk);
        spm_store <= 1'b0;
        // Scramble the data so a late sample cannot pass.
        r1_r0 <= ~d;
    endtask
    task automatic load(input logic [15:0] z);
        lpm_load <= 1'b1;
        z_ptr <= z;
        @(posedge pclk);
        lpm_load <= 1'b0;
        z_ptr <= ~z;
    endtask
endmodule
`default_nettype wire

//--- tb/tb_self_program_control_and_lock.sv
/*
 * Self-checking bench: APB master, core model, table of store cases.
 * Assumes the sequencer with a short busy count of four cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_self_program_control_and_lock;
    import selfprog_pkg::*;
    typedef struct packed {
        logic [4:0] cmd; logic [2:0] dly; logic [15:0] z; logic [15:0] d;
        logic fill; logic ers; logic wrt; logic rww; logic stall;
    } row_s;
    logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, load_data;
    logic [31:0] pwdata, prdata, v;
    logic spm_store, lpm_load, exec_boot, vectors_in_boot, global_irq_en, load_valid;
    logic load_denied, fill_strobe, page_erase_go, page_write_go, core_stall, rww_read_block;
    logic store_ready_irq, irq_allowed, ext_prog_allowed, ext_verify_allowed, fuse_change_allowed;
    logic [15:0] z_ptr, r1_r0, fill_addr, fill_data, page_addr;
    int mismatches = 0, tests_run = 0;
    row_s rows [8];
    always #10 pclk = ~pclk;
    selfprog_ctrl #(.OP_CYCLES(8'd4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .spm_store(spm_store), .lpm_load(lpm_load),
        .z_ptr(z_ptr), .r1_r0(r1_r0), .exec_boot(exec_boot), .vectors_in_boot(vectors_in_boot),
        .global_irq_en(global_irq_en), .load_data(load_data), .load_valid(load_valid),
        .load_denied(load_denied), .fill_strobe(fill_strobe), .fill_addr(fill_addr),
        .fill_data(fill_data), .page_erase_go(page_erase_go), .page_write_go(page_write_go),
        .page_addr(page_addr), .core_stall(core_stall), .rww_read_block(rww_read_block),
        .store_ready_irq(store_ready_irq), .irq_allowed(irq_allowed),
        .ext_prog_allowed(ext_prog_allowed), .ext_verify_allowed(ext_verify_allowed),
        .fuse_change_allowed(fuse_change_allowed));
    core_model core_u (.pclk(pclk), .core_stall(core_stall), .spm_store(spm_store),
        .lpm_load(lpm_load), .z_ptr(z_ptr), .r1_r0(r1_r0));
    // ========================================================================
    // Checking, bus and closing tasks.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // The master waits for pready as long as it takes; only the watchdog ends a hang.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        // An idle edge first, so a release and a new setup never share a time step.
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        e = pslverr;
        v = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        conclude();
    end
    // ========================================================================
    // Main sequence: reset values, table of store cases, then awkward cases.
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
        exec_boot = 0; vectors_in_boot = 0; global_irq_en = 0;
        rows[0] = '{CMD_FILL, 3'd1, 16'h1235, 16'hBEEF, 1, 0, 0, 0, 0};
        rows[1] = '{CMD_ERASE, 3'd2, 16'h1000, 16'h0000, 0, 1, 0, 1, 0};
        rows[2] = '{CMD_RWW_EN, 3'd1, 16'h0000, 16'h0000, 0, 0, 0, 0, 0};
        rows[3] = '{CMD_WRITE, 3'd4, 16'hF000, 16'h0000, 0, 0, 1, 0, 1};
        rows[4] = '{CMD_FILL, 3'd5, 16'h0002, 16'h1111, 0, 0, 0, 0, 0};
        rows[5] = '{5'h07, 3'd1, 16'h0000, 16'h0000, 0, 0, 0, 0, 0};
        rows[6] = '{CMD_LOCKSET, 3'd1, 16'h1234, 16'h55FB, 0, 0, 0, 0, 0};
        rows[7] = '{CMD_ERASE, 3'd1, 16'h1000, 16'h0000, 0, 0, 0, 0, 0};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, LOCK_OFFSET, 32'h0); chk(v[7:0], LOCK_RESET);
        apb(1'b0, CTRL_OFFSET, 32'h0); chk(v[7:0], 8'h00);
        foreach (rows[i]) begin
            apb(1'b1, CTRL_OFFSET, {27'h0, rows[i].cmd});
            repeat (rows[i].dly - 1) @(posedge pclk);
            core_u.store(rows[i].z, rows[i].d);
            #1;
            chk(fill_strobe, rows[i].fill);
            chk(page_erase_go, rows[i].ers);
            chk(page_write_go, rows[i].wrt);
            chk(rww_read_block, rows[i].rww);
            chk(core_stall, rows[i].stall);
            if (rows[i].fill) chk({rows[i].d, rows[i].z & 16'hFFFE}, {fill_data, fill_addr});
            if (rows[i].ers | rows[i].wrt) chk(page_addr, rows[i].z & 16'hFF00);
            @(posedge pclk);
            apb(1'b0, CTRL_OFFSET, 32'h0); chk(v[STORE_EN_BIT], rows[i].ers | rows[i].wrt);
            repeat (10) @(posedge pclk);
        end
        // Lock and fuse reads through the load path.
        apb(1'b1, CTRL_OFFSET, {27'h0, CMD_LOCKSET}); core_u.load(16'h0000);
        #1; chk({load_valid, load_data}, {1'b1, 8'hFB});
        repeat (10) @(posedge pclk);
        apb(1'b1, CTRL_OFFSET, {27'h0, CMD_LOCKSET}); core_u.load(16'h0001);
        #1; chk({load_valid, load_data}, {1'b1, FUSE_RESET});
        repeat (10) @(posedge pclk);
        // Ones in r0 must not unprogram a lock bit; only chip erase does.
        apb(1'b1, CTRL_OFFSET, {27'h0, CMD_LOCKSET}); core_u.store(16'h0000, 16'h00FF);
        repeat (10) @(posedge pclk);
        apb(1'b0, LOCK_OFFSET, 32'h0); chk(v[7:0], 8'hFB);
        apb(1'b1, ERASE_OFFSET, {24'h0, CHIP_ERASE_KEY});
        apb(1'b0, LOCK_OFFSET, 32'h0); chk(v[7:0], LOCK_RESET);
        // External lock modes two and three, then application mode three.
        apb(1'b1, FUSE_OFFSET, 32'hFD);
        apb(1'b1, LOCK_OFFSET, 32'hFE); #1;
        chk({fuse_change_allowed, ext_prog_allowed, ext_verify_allowed}, 3'b001);
        @(posedge pclk);
        apb(1'b1, LOCK_OFFSET, 32'hFC); #1; chk(ext_verify_allowed, 0);
        @(posedge pclk);
        apb(1'b1, ERASE_OFFSET, {24'h0, CHIP_ERASE_KEY});
        vectors_in_boot <= 1'b1;
        apb(1'b1, LOCK_OFFSET, 32'hF3); #1; chk(irq_allowed, 0);
        @(posedge pclk);
        // Boot-side code may not read the application section in this mode.
        exec_boot <= 1'b1; core_u.load(16'h0000);
        #1; chk(load_denied, 1);
        apb(1'b1, ERASE_OFFSET, {24'h0, CHIP_ERASE_KEY});
        apb(1'b1, 8'h20, 32'h0); chk(e, 1);
        // Store-ready interrupt follows the store enable bit.
        global_irq_en <= 1'b1;
        apb(1'b1, CTRL_OFFSET, 32'h81); #1; chk(store_ready_irq, 0);
        repeat (6) @(posedge pclk);
        #1; chk(store_ready_irq, 1);
        @(posedge pclk);
        global_irq_en <= 1'b0;
        @(posedge pclk);
        #1; chk(store_ready_irq, 0);
        conclude();
    end
endmodule
`default_nettype wire
